// ---- src/ersf_consts.svh ----
// timing counts, led positions and list sizes for the room status machine
// assumes a single 125 mhz system clock; counts are derived from times below
`ifndef ERSF_CONSTS_SVH
`define ERSF_CONSTS_SVH

`define ERSF_CLK_KHZ          125000

// stable time before a button change counts
`define ERSF_DEBOUNCE_MS      10
// quiet time before a multi-press jump commits
`define ERSF_COMMIT_MS        500
// one full blink period
`define ERSF_BLINK_MS         1000

`define ERSF_DEBOUNCE_CYCLES  (`ERSF_DEBOUNCE_MS * `ERSF_CLK_KHZ)
`define ERSF_COMMIT_CYCLES    (`ERSF_COMMIT_MS * `ERSF_CLK_KHZ)
`define ERSF_BLINK_CYCLES     (`ERSF_BLINK_MS * `ERSF_CLK_KHZ)

`define ERSF_DUTY_WAITING_PCT 50
`define ERSF_DUTY_PRESENT_PCT 10

// station led list: physicians from the top, then assistant, then white
`define ERSF_LED_COUNT        9
`define ERSF_PHYS_COUNT       7
`define ERSF_LED_ASSIST       7
`define ERSF_LED_WHITE        8

`define ERSF_BTN_COUNT        3
`define ERSF_BTN_STATUS       0
`define ERSF_BTN_READY        1
`define ERSF_BTN_PICK         2

// press count ceilings in clean and assistant states
`define ERSF_MAX_PRESS_CLEAN  2'h3
`define ERSF_MAX_PRESS_ASSIST 2'h2

`endif

// ---- src/ersf_pkg.sv ----
// types shared by the exam room status machine files
// no constants here; numbers live in ersf_consts.svh
package ersf_pkg;

    // room activity states in cycle order; jumps add a press count to the code
    typedef enum logic [2:0]
    {
        st_clean,
        st_assist,
        st_changing,
        st_ready,
        st_phys_in,
        st_dirty
    } ersf_state_t;

endpackage : ersf_pkg

// ---- src/ersf_debounce.sv ----
// synchroniser and debouncer for a bank of push buttons
// assumes active-high raw levels; one press pulse per accepted rising change
`timescale 1ns/1ns
`default_nettype none

module ersf_debounce #(
    parameter int unsigned WIDTH         = 3,
    parameter int unsigned STABLE_CYCLES = 1250000
) (
    // clock, reset, enable
    input  wire logic             ref_clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             ce_in,
    // raw buttons
    input  wire logic [WIDTH-1:0] raw_in,
    // clean levels and press pulses
    output logic      [WIDTH-1:0] level_out,
    output logic      [WIDTH-1:0] press_out
);

    localparam int unsigned CW = $clog2(STABLE_CYCLES + 1);

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : g_btn
            logic          sync0_r;
            logic          sync1_r;
            logic [CW-1:0] cnt_r;
            logic [CW-1:0] cnt_nxt;
            logic          level_nxt;
            logic          press_nxt;

            always_comb
            begin
                cnt_nxt   = '0;
                level_nxt = level_out[g];
                press_nxt = 1'b0;
                if (sync1_r != level_out[g])
                begin
                    if (cnt_r == CW'(STABLE_CYCLES - 1))
                    begin
                        level_nxt = sync1_r;
                        press_nxt = sync1_r;
                    end
                    else
                    begin
                        cnt_nxt = cnt_r + 1'b1;
                    end
                end
            end

            always_ff @(posedge ref_clk_in or negedge rst_n_in)
            begin
                if (!rst_n_in)
                begin
                    sync0_r      <= 1'b0;
                    sync1_r      <= 1'b0;
                    cnt_r        <= '0;
                    level_out[g] <= 1'b0;
                    press_out[g] <= 1'b0;
                end
                else if (ce_in)
                begin
                    sync0_r      <= raw_in[g];
                    sync1_r      <= sync0_r;
                    cnt_r        <= cnt_nxt;
                    level_out[g] <= level_nxt;
                    press_out[g] <= press_nxt;
                end
            end
        end
    endgenerate

endmodule : ersf_debounce

`default_nettype wire

// ---- src/ersf_blink.sv ----
// free-running blink source: 50 and 10 percent on phases
// assumes the period is at least ten cycles so both phases are non-empty
`timescale 1ns/1ns
`default_nettype none

`include "ersf_consts.svh"

module ersf_blink #(
    parameter int unsigned PERIOD_CYCLES = 125000000
) (
    // clock, reset, enable
    input  wire logic ref_clk_in,
    input  wire logic rst_n_in,
    input  wire logic ce_in,
    // blink phases, high while lit
    output logic      half_out,
    output logic      tenth_out
);

    localparam int unsigned CW       = $clog2(PERIOD_CYCLES);
    // divide rather than multiply so the figures never overflow 32 bits
    localparam int unsigned HALF_LEN = PERIOD_CYCLES / (100 / `ERSF_DUTY_WAITING_PCT);
    localparam int unsigned TENTH_LEN = PERIOD_CYCLES / (100 / `ERSF_DUTY_PRESENT_PCT);

    logic [CW-1:0] phase_r;
    logic [CW-1:0] phase_nxt;
    logic          half_nxt;
    logic          tenth_nxt;

    always_comb
    begin
        if (phase_r == CW'(PERIOD_CYCLES - 1))
        begin
            phase_nxt = '0;
        end
        else
        begin
            phase_nxt = phase_r + 1'b1;
        end
        half_nxt  = (phase_nxt < CW'(HALF_LEN));
        tenth_nxt = (phase_nxt < CW'(TENTH_LEN));
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            phase_r   <= '0;
            half_out  <= 1'b0;
            tenth_out <= 1'b0;
        end
        else if (ce_in)
        begin
            phase_r   <= phase_nxt;
            half_out  <= half_nxt;
            tenth_out <= tenth_nxt;
        end
    end

endmodule : ersf_blink

`default_nettype wire

// ---- src/ersf_exam_room_status.sv ----
// room status state machine for one in-wall exam room station
// assumes buttons and queue levels are active high, synchronous to ref_clk_in
//
// Behaviour
// - reset lands in the clean, unoccupied room state
// - clean room: white led steadily on
// - clean room: one, two or three presses go to assistant, changing, ready
// - assistant inside: assistant led on; one press changing, two presses ready
// - patient changing: no station led lit or blinking
// - patient changing: ready button or status press go to patient ready
// - patient ready: physician led steady when queued, 50% blink when next
// - patient ready: status press goes to physician present
// - physician present: physician led blinks at 10% duty
// - physician present: status press goes to needs cleaning
// - physician present: in-room green led on while another room waits
// - needs cleaning: white led blinks
// - needs cleaning: status press returns to clean room
// - each list led is one physician; the lit one is assigned
// - physician pick only in clean, assistant, changing and ready states
// - with no pick made, the top physician of the list is assigned
// - status presses with pick button held step the physician instead
// - seven physician leds bound the physician list; nine station leds bound the led vector
`timescale 1ns/1ns
`default_nettype none

`include "ersf_consts.svh"

module ersf_exam_room_status #(
    parameter int unsigned PHYS_COUNT      = `ERSF_PHYS_COUNT,
    parameter int unsigned DEBOUNCE_CYCLES = `ERSF_DEBOUNCE_CYCLES,
    parameter int unsigned COMMIT_CYCLES   = `ERSF_COMMIT_CYCLES,
    parameter int unsigned BLINK_CYCLES    = `ERSF_BLINK_CYCLES
) (
    // clock, reset and enable
    input  wire logic                          ref_clk_in,
    input  wire logic                          rst_n_in,
    input  wire logic                          ce_in,
    // station push buttons
    input  wire logic                          status_button_in,
    input  wire logic                          physician_pick_button_in,
    // in-room station button
    input  wire logic                          ready_button_in,
    // queue information from the network side
    input  wire logic                          next_in_line_in,
    input  wire logic                          other_room_waiting_in,
    // station list leds and in-room green led
    output logic      [`ERSF_LED_COUNT-1:0]    station_led_out,
    output logic                               green_led_out,
    // state and pick for the network side
    output logic      [2:0]                    room_state_out,
    output logic      [$clog2(PHYS_COUNT)-1:0] physician_out
);

    localparam int unsigned PW = $clog2(PHYS_COUNT);
    localparam int unsigned IW = $clog2(COMMIT_CYCLES + 1);

    // cleaned button levels and press pulses
    logic [`ERSF_BTN_COUNT-1:0] btn_raw;
    logic [`ERSF_BTN_COUNT-1:0] btn_level;
    logic [`ERSF_BTN_COUNT-1:0] btn_press;
    logic                       status_press;
    logic                       ready_press;
    logic                       pick_held;

    // blink phases
    logic                       blink_half;
    logic                       blink_tenth;

    // state group
    ersf_pkg::ersf_state_t      state_r;
    ersf_pkg::ersf_state_t      state_nxt;
    logic [PW-1:0]              phys_r;
    logic [PW-1:0]              phys_nxt;
    logic [1:0]                 press_cnt_r;
    logic [1:0]                 press_cnt_nxt;
    logic [IW-1:0]              idle_cnt_r;
    logic [IW-1:0]              idle_cnt_nxt;

    // output group
    logic [`ERSF_LED_COUNT-1:0] led_nxt;
    logic                       green_nxt;

    // helpers
    logic                       pick_allowed;
    logic                       counting_state;
    logic [1:0]                 press_max;
    logic                       counted_press;

    assign btn_raw[`ERSF_BTN_STATUS] = status_button_in;
    assign btn_raw[`ERSF_BTN_READY]  = ready_button_in;
    assign btn_raw[`ERSF_BTN_PICK]   = physician_pick_button_in;

    ersf_debounce #(
        .WIDTH         (`ERSF_BTN_COUNT),
        .STABLE_CYCLES (DEBOUNCE_CYCLES)
    ) u_debounce (
        .ref_clk_in (ref_clk_in),
        .rst_n_in   (rst_n_in),
        .ce_in      (ce_in),
        .raw_in     (btn_raw),
        .level_out  (btn_level),
        .press_out  (btn_press)
    );

    assign status_press = btn_press[`ERSF_BTN_STATUS];
    assign ready_press  = btn_press[`ERSF_BTN_READY];
    assign pick_held    = btn_level[`ERSF_BTN_PICK];

    ersf_blink #(
        .PERIOD_CYCLES (BLINK_CYCLES)
    ) u_blink (
        .ref_clk_in (ref_clk_in),
        .rst_n_in   (rst_n_in),
        .ce_in      (ce_in),
        .half_out   (blink_half),
        .tenth_out  (blink_tenth)
    );

    assign pick_allowed = (state_r == ersf_pkg::st_clean)
                        || (state_r == ersf_pkg::st_assist)
                        || (state_r == ersf_pkg::st_changing)
                        || (state_r == ersf_pkg::st_ready);

    // only clean and assistant accept multi-press jumps
    assign counting_state = (state_r == ersf_pkg::st_clean)
                          || (state_r == ersf_pkg::st_assist);
    assign press_max      = (state_r == ersf_pkg::st_clean) ? `ERSF_MAX_PRESS_CLEAN
                                                            : `ERSF_MAX_PRESS_ASSIST;

    // status presses under the pick button never move the room state
    assign counted_press  = status_press && !pick_held;

    // state group: next values
    always_comb
    begin
        state_nxt     = state_r;
        phys_nxt      = phys_r;
        press_cnt_nxt = press_cnt_r;
        idle_cnt_nxt  = idle_cnt_r;

        // step the physician, wrapping to the top
        if (status_press && pick_held && pick_allowed)
        begin
            if (phys_r == PW'(PHYS_COUNT - 1))
            begin
                phys_nxt = '0;
            end
            else
            begin
                phys_nxt = phys_r + 1'b1;
            end
        end

        if (counting_state)
        begin
            // gather presses, commit once the button goes quiet
            if (counted_press)
            begin
                if (press_cnt_r != press_max)
                begin
                    press_cnt_nxt = press_cnt_r + 1'b1;
                end
                idle_cnt_nxt = '0;
            end
            else if (press_cnt_r != 2'h0)
            begin
                if (idle_cnt_r == IW'(COMMIT_CYCLES - 1))
                begin
                    press_cnt_nxt = 2'h0;
                    idle_cnt_nxt  = '0;
                    // jump by press count from clean room
                    // jump by press count from assistant inside
                    state_nxt     = ersf_pkg::ersf_state_t'(state_r + press_cnt_r);
                end
                else
                begin
                    idle_cnt_nxt = idle_cnt_r + 1'b1;
                end
            end
        end
        else
        begin
            press_cnt_nxt = 2'h0;
            idle_cnt_nxt  = '0;
            unique case (state_r)
                ersf_pkg::st_changing:
                begin
                    if (counted_press || ready_press)
                    begin
                        state_nxt = ersf_pkg::st_ready;
                    end
                end
                ersf_pkg::st_ready:
                begin
                    if (counted_press)
                    begin
                        state_nxt = ersf_pkg::st_phys_in;
                    end
                end
                ersf_pkg::st_phys_in:
                begin
                    if (counted_press)
                    begin
                        state_nxt = ersf_pkg::st_dirty;
                    end
                end
                ersf_pkg::st_dirty:
                begin
                    if (counted_press)
                    begin
                        state_nxt = ersf_pkg::st_clean;
                    end
                end
                // illegal code recovers to clean room
                default:
                begin
                    state_nxt = ersf_pkg::st_clean;
                end
            endcase
        end
    end

    // state group: registers
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_r     <= ersf_pkg::st_clean;
            // top of the list until a pick is made
            phys_r      <= '0;
            press_cnt_r <= 2'h0;
            idle_cnt_r  <= '0;
        end
        else if (ce_in)
        begin
            state_r     <= state_nxt;
            phys_r      <= phys_nxt;
            press_cnt_r <= press_cnt_nxt;
            idle_cnt_r  <= idle_cnt_nxt;
        end
    end

    // output group: next values
    always_comb
    begin
        led_nxt   = '0;
        green_nxt = 1'b0;
        unique case (state_r)
            ersf_pkg::st_clean:
            begin
                led_nxt[`ERSF_LED_WHITE] = 1'b1;
            end
            ersf_pkg::st_assist:
            begin
                led_nxt[`ERSF_LED_ASSIST] = 1'b1;
            end
            ersf_pkg::st_changing:
            begin
                led_nxt = '0;
            end
            ersf_pkg::st_ready:
            begin
                // queued steady, next in line blinks
                // the lit list led names the physician
                led_nxt[phys_r] = next_in_line_in ? blink_half : 1'b1;
            end
            ersf_pkg::st_phys_in:
            begin
                led_nxt[phys_r] = blink_tenth;
                green_nxt       = other_room_waiting_in;
            end
            ersf_pkg::st_dirty:
            begin
                led_nxt[`ERSF_LED_WHITE] = blink_half;
            end
            default:
            begin
                led_nxt = '0;
            end
        endcase
    end

    // output group: registers
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            // nine leds, all dark in reset
            station_led_out <= '0;
            green_led_out   <= 1'b0;
            room_state_out  <= 3'h0;
            physician_out   <= '0;
        end
        else if (ce_in)
        begin
            station_led_out <= led_nxt;
            green_led_out   <= green_nxt;
            room_state_out  <= 3'(state_r);
            physician_out   <= phys_r;
        end
    end

endmodule : ersf_exam_room_status

`default_nettype wire

// ---- verif/ersf_station_model.sv ----
// push-button station model: raw button levels with contact bounce
// assumes calls start just after a rising clock edge; released lines idle low
`timescale 1ns/1ns
`default_nettype none

module ersf_station_model (
    // clock
    input  wire logic       ref_clk_in,
    // raw buttons: status, ready, pick
    output logic      [2:0] raw_out
);
    initial raw_out = 3'h0;

    // bounce is shorter than the debounce window: never a press
    task automatic press(input int idx, input int hold, input bit bounce);
        if (bounce)
        begin
            raw_out[idx] = 1'b1;
            @(posedge ref_clk_in);
            #1 raw_out[idx] = 1'b0;
            repeat (2) @(posedge ref_clk_in);
            #1;
        end
        raw_out[idx] = 1'b1;
        repeat (hold) @(posedge ref_clk_in);
        #1 raw_out[idx] = 1'b0;
        repeat (8) @(posedge ref_clk_in);
        #1;
    endtask : press

    // pick level must settle before status presses use it
    task automatic set_pick(input bit v);
        raw_out[2] = v;
        repeat (8) @(posedge ref_clk_in);
        #1;
    endtask : set_pick
endmodule : ersf_station_model

`default_nettype wire

// ---- verif/ersf_exam_room_status_monitor.sv ----
// port checker for the exam room status machine
// assumes a bind from the bench top; one clock, async active-low reset
`timescale 1ns/1ns
`default_nettype none

`include "ersf_consts.svh"

module ersf_exam_room_status_monitor #(
    parameter int unsigned PHYS_COUNT = 7
) (
    // clock, reset
    input wire logic                          ref_clk_in,
    input wire logic                          rst_n_in,
    // queue levels
    input wire logic                          next_in_line_in,
    input wire logic                          other_room_waiting_in,
    // leds, state and assignment
    input wire logic [`ERSF_LED_COUNT-1:0]    station_led_out,
    input wire logic                          green_led_out,
    input wire logic [2:0]                    room_state_out,
    input wire logic [$clog2(PHYS_COUNT)-1:0] physician_out
);
    logic [2:0]                    st;
    logic                          any_ph;
    logic [$clog2(PHYS_COUNT)-1:0] ph_next;

    assign st     = room_state_out;
    assign any_ph = |station_led_out[6:0];

    always_comb
    begin
        ph_next = physician_out + 1'b1;
        if (physician_out == PHYS_COUNT - 1)
            ph_next = '0;
    end

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    chk_reset_clean: assert property (
        !$past(rst_n_in) |-> st == 3'h0 && physician_out == '0)
        else $error("state or pick not cleared after reset");
    chk_clean_white: assert property (
        $past(rst_n_in) && st == 3'h0 |-> station_led_out[8:7] == 2'b10)
        else $error("white led not steady in clean room");
    chk_assist_led: assert property (
        st == 3'h1 |-> station_led_out[8:7] == 2'b01)
        else $error("assistant led wrong");
    chk_changing_dark: assert property (
        st == 3'h2 |-> station_led_out == '0)
        else $error("led lit while patient changing");
    chk_ready_steady: assert property (
        st == 3'h3 && !$past(next_in_line_in) |-> $onehot(station_led_out))
        else $error("queued room led not steady");
    chk_present_tenth: assert property (
        st == 3'h4 && $rose(any_ph) ##1 st == 3'h4 ##1 st == 3'h4 |-> !any_ph)
        else $error("physician led lit too long while present");
    chk_dirty_on: assert property (
        st == 3'h5 && $past(st) == 3'h5 && $rose(station_led_out[8])
        |=> (station_led_out[8] || st != 3'h5) [*8])
        else $error("white blink on phase too short");
    chk_dirty_off: assert property (
        st == 3'h5 && $past(st) == 3'h5 && $fell(station_led_out[8])
        |=> (!station_led_out[8] || st != 3'h5) [*8])
        else $error("white blink off phase too short");
    chk_green_gate: assert property (
        green_led_out |-> st == 3'h4)
        else $error("green led outside physician present");
    chk_green_follow: assert property (
        st == 3'h4 |-> green_led_out == $past(other_room_waiting_in))
        else $error("green led does not follow waiting room");
    chk_state_order: assert property (
        $changed(st) |-> st == $past(st) + 3'h1 || (st == 3'h0 && $past(st) == 3'h5)
        || ($past(st) == 3'h0 && st inside {3'h2, 3'h3}) || ($past(st) == 3'h1 && st == 3'h3))
        else $error("illegal room state step");
    chk_pick_states: assert property (
        $changed(physician_out) |-> $past(st) <= 3'h3)
        else $error("physician changed in a locked state");
    chk_pick_step: assert property (
        $changed(physician_out) |-> physician_out == $past(ph_next))
        else $error("physician did not step by one");

    cov_green: cover property (st == 3'h4 && green_led_out);
    cov_dirty: cover property (st == 3'h5 && station_led_out[8]);
    cov_wrap: cover property ($changed(physician_out) && physician_out == '0);
endmodule : ersf_exam_room_status_monitor

`default_nettype wire

// ---- verif/ersf_exam_room_status_tb_top.sv ----
// self-checking bench for the exam room status machine
// assumes short debounce, commit and blink counts
`timescale 1ns/1ns
`default_nettype none

`include "ersf_consts.svh"

module ersf_exam_room_status_tb_top;
    localparam int unsigned DEB   = 4;
    localparam int unsigned COMM  = 40;
    localparam int unsigned BLINK = 20;

    logic        ref_clk_in    = 1'b0;
    logic        rst_n_in      = 1'b0;
    logic        ce_in         = 1'b1;
    logic        next_in_line  = 1'b0;
    logic        other_waiting = 1'b0;
    wire logic [2:0] raw;
    logic [8:0]  led;
    logic        green;
    logic [2:0]  room_st;
    logic [2:0]  phys;
    logic [31:0] lfsr          = 32'h1b75fcc0;
    logic [2:0]  exp_st        = 3'h0;
    logic [2:0]  exp_ph        = 3'h0;
    int          n_fail          = 0;
    int          samples_checked = 0;
    int          cyc             = 0;

    always #4 ref_clk_in = ~ref_clk_in;

    ersf_station_model u_station (
        .ref_clk_in (ref_clk_in),
        .raw_out    (raw)
    );

    ersf_exam_room_status #(
        .PHYS_COUNT      (`ERSF_PHYS_COUNT),
        .DEBOUNCE_CYCLES (DEB),
        .COMMIT_CYCLES   (COMM),
        .BLINK_CYCLES    (BLINK)
    ) u_dut (
        .ref_clk_in               (ref_clk_in),
        .rst_n_in                 (rst_n_in),
        .ce_in                    (ce_in),
        .status_button_in         (raw[0]),
        .physician_pick_button_in (raw[2]),
        .ready_button_in          (raw[1]),
        .next_in_line_in          (next_in_line),
        .other_room_waiting_in    (other_waiting),
        .station_led_out          (led),
        .green_led_out            (green),
        .room_state_out           (room_st),
        .physician_out            (phys)
    );

    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_next

    function automatic logic [2:0] room_after(input logic [2:0] s, input int n);
        if (s == 3'h0)
            return 3'(n);
        if (s == 3'h5)
            return 3'h0;
        return s + 3'(n);
    endfunction : room_after

    task automatic rnd(output int v, input int m);
        lfsr = lfsr_next(lfsr);
        v = int'(lfsr[15:0]) % m;
    endtask : rnd

    task automatic check(input string what, input logic [8:0] want, input logic [8:0] got);
        samples_checked++;
        if (got !== want)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, want, got);
        end
    endtask : check

    task automatic settle;
        repeat (COMM + 8) @(posedge ref_clk_in);
        #1;
    endtask : settle

    // one blink period gives the lit share at any phase
    task automatic lit_count(input int b, output int c);
        c = 0;
        repeat (BLINK)
        begin
            @(posedge ref_clk_in);
            #1 c += int'(led[b]);
        end
    endtask : lit_count

    task automatic visit;
        int c;
        case (exp_st)
            3'h1: check("led", 9'h080, led & 9'h180);
            3'h2: check("led", 9'h000, led);
            3'h3:
            begin
                rnd(c, 2);
                next_in_line = c[0];
                repeat (3) @(posedge ref_clk_in);
                #1;
                if (!next_in_line)
                    check("led", 9'h001 << exp_ph, led);
                else
                begin
                    lit_count(int'(exp_ph), c);
                    check("half", 9'(BLINK / 2), 9'(c));
                end
            end
            3'h4:
            begin
                rnd(c, 2);
                other_waiting = c[0];
                u_station.set_pick(1'b1);
                u_station.press(0, 8, 1'b0);
                u_station.set_pick(1'b0);
                check("state", 9'h004, 9'(room_st));
                check("pick", 9'(exp_ph), 9'(phys));
                check("green", 9'(other_waiting), 9'(green));
                lit_count(int'(exp_ph), c);
                check("tenth", 9'(BLINK / 10), 9'(c));
            end
            default:
            begin
                lit_count(8, c);
                check("white", 9'(BLINK / 2), 9'(c));
            end
        endcase
    endtask : visit

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop

    always @(posedge ref_clk_in)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            n_fail++;
            report_and_stop();
        end
    end

    initial
    begin : main
        int r, n, h, c, k;
        repeat (12) @(posedge ref_clk_in);
        #1 rst_n_in = 1'b1;
        repeat (3) @(posedge ref_clk_in);
        #1;
        check("state", 9'h000, 9'(room_st));
        check("led", 9'h100, led);
        check("pick", 9'h000, 9'(phys));
        for (r = 0; r < 6; r++)
        begin
            rnd(k, 8);
            u_station.set_pick(1'b1);
            repeat (k + 1) u_station.press(0, 8, 1'b0);
            u_station.set_pick(1'b0);
            settle();
            exp_ph = 3'((int'(exp_ph) + k + 1) % `ERSF_PHYS_COUNT);
            check("pick", 9'(exp_ph), 9'(phys));
            check("state", 9'h000, 9'(room_st));
            n = (r % 3) + 1;
            if (r >= 3)
            begin
                u_station.press(0, 8, 1'b0);
                settle();
                exp_st = 3'h1;
                visit();
                n = (r % 2) + 1;
            end
            repeat (n) u_station.press(0, 8, 1'b0);
            settle();
            exp_st = room_after(exp_st, n);
            check("state", 9'(exp_st), 9'(room_st));
            while (exp_st != 3'h0)
            begin
                visit();
                rnd(h, 32);
                rnd(c, 2);
                u_station.press((exp_st == 3'h2 && c == 1) ? 1 : 0, h + 8, lfsr[20]);
                settle();
                exp_st = room_after(exp_st, 1);
                check("state", 9'(exp_st), 9'(room_st));
            end
        end
        repeat (3) u_station.press(0, 8, 1'b0);
        settle();
        u_station.press(0, 10, 1'b0);
        settle();
        check("state", 9'h004, 9'(room_st));
        rst_n_in = 1'b0;
        repeat (3) @(posedge ref_clk_in);
        #1 rst_n_in = 1'b1;
        repeat (3) @(posedge ref_clk_in);
        #1;
        check("state", 9'h000, 9'(room_st));
        check("pick", 9'h000, 9'(phys));
        ce_in = 1'b0;
        u_station.press(0, 8, 1'b0);
        ce_in = 1'b1;
        settle();
        check("state", 9'h000, 9'(room_st));
        report_and_stop();
    end
endmodule : ersf_exam_room_status_tb_top

bind ersf_exam_room_status ersf_exam_room_status_monitor #(.PHYS_COUNT(PHYS_COUNT)) u_mon (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .next_in_line_in(next_in_line_in),
    .other_room_waiting_in(other_room_waiting_in), .station_led_out(station_led_out),
    .green_led_out(green_led_out), .room_state_out(room_state_out),
    .physician_out(physician_out)
);

`default_nettype wire
